// [logic/flash_array.sv]
`timescale 1ns/100ps
`default_nettype none
// Behavioural flash array: main and information blocks held in flip-flops.
module flash_array #(
  parameter int AW   = 13,
  parameter int DW   = 16,
  parameter int IW   = 6,
  parameter int PAGE = 5
) (
  // Clock and reset.
  input  wire logic  CLK_SYS,
  input  wire logic  ARST_N,
  // Array side.
  flash_array_if.array FA,
  // Observed mode.
  output var  logic [4:0] MODE
);

  logic [DW-1:0] main_mem [2**AW];
  logic [DW-1:0] info_mem [2**IW];
  logic [DW-1:0] rd_word;
  logic          hv_rise;
  logic          hv_prev;
  logic          is_read;
  logic          is_write_pulse;
  logic          is_perase;
  logic          is_merase;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode from strobe patterns.
  assign is_read   = FA.row_select & FA.column_gate & FA.read_amplifier_on & FA.dout_drive & ~FA.write_pulse
                     & ~FA.clear_pulse & ~FA.whole_array & ~FA.hv_store;
  assign is_write_pulse   = FA.row_select & FA.column_gate & FA.write_pulse & FA.hv_store & ~FA.read_amplifier_on
                     & ~FA.dout_drive & ~FA.clear_pulse & ~FA.whole_array;
  assign is_perase = FA.row_select & FA.clear_pulse & FA.hv_store & ~FA.column_gate & ~FA.read_amplifier_on
                     & ~FA.dout_drive & ~FA.write_pulse & ~FA.whole_array;
  assign is_merase = FA.row_select & FA.clear_pulse & FA.hv_store & FA.whole_array & ~FA.column_gate
                     & ~FA.read_amplifier_on & ~FA.dout_drive & ~FA.write_pulse;
  assign hv_rise   = FA.hv_store & ~hv_prev;

  // Edge tracker for the store phase.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      hv_prev <= 1'b0;
    end else begin
      hv_prev <= FA.hv_store;
    end
  end

  // Program clears bits, erase sets them; info_block_sel chooses the block, but mass erase always erases main.
  always_ff @(posedge CLK_SYS) begin
    if (hv_rise && is_write_pulse) begin
      if (FA.info_block_sel) begin
        info_mem[FA.addr[IW-1:0]] <= info_mem[FA.addr[IW-1:0]] & FA.din;
      end else begin
        main_mem[FA.addr] <= main_mem[FA.addr] & FA.din;
      end
    end
    for (int i = 0; i < 2**AW; i++) begin
      if (hv_rise && is_merase) begin
        main_mem[i] <= '1;
      end else if (hv_rise && is_perase && !FA.info_block_sel && (i >> PAGE) == (FA.addr >> PAGE)) begin
        main_mem[i] <= '1;
      end
    end
    for (int j = 0; j < 2**IW; j++) begin
      if (hv_rise && FA.info_block_sel && (is_merase || is_perase)) begin
        info_mem[j] <= '1;
      end
    end
  end

  // Read path and output drive; bus floats when dout_drive is low.
  assign rd_word = FA.info_block_sel ? info_mem[FA.addr[IW-1:0]] : main_mem[FA.addr];
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      FA.dout    <= '0;
      FA.dout_oe <= 1'b0;
    end else begin
      FA.dout    <= is_read ? rd_word : '0;
      FA.dout_oe <= is_read;
    end
  end

  // Mode report; 5'h01 means standby with all rows deselected.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      MODE <= 5'h00;
    end else begin
      MODE <= {is_merase, is_perase, is_write_pulse, is_read, ~FA.row_select};
    end
  end

endmodule : flash_array
`default_nettype wire

// [logic/flash_array_if.sv]
`timescale 1ns/100ps
`default_nettype none
// Strobes, address and data between the controller and the flash array.
interface flash_array_if #(parameter int AW = 13, parameter int DW = 16);
  logic          row_select;
  logic          column_gate;
  logic          read_amplifier_on;
  logic          dout_drive;
  logic          write_pulse;
  logic          clear_pulse;
  logic          whole_array;
  logic          hv_store;
  logic          info_block_sel;
  logic [AW-1:0] addr;
  logic [DW-1:0] din;
  logic [DW-1:0] dout;
  logic          dout_oe;

  modport ctrl (output row_select, column_gate, read_amplifier_on, dout_drive, write_pulse, clear_pulse,
                output whole_array, hv_store, info_block_sel, addr, din, input dout, dout_oe);
  modport array (input row_select, column_gate, read_amplifier_on, dout_drive, write_pulse, clear_pulse,
                 input whole_array, hv_store, info_block_sel, addr, din, output dout, dout_oe);
endinterface : flash_array_if
`default_nettype wire

// [logic/flash_ctrl.sv]
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Flash interface controller: APB registers drive a manual strobe sequencer.
module flash_ctrl #(
  parameter int AW = 13,
  parameter int DW = 16,
  parameter int HV_LIMIT = flash_seq_pkg::HV_CYC,
  parameter int ROWS = 64,
  parameter int ROW_SH = 7
) (
  // Clock and reset.
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  // Flash strobes.
  flash_array_if.ctrl      FA
);

  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_RDEN = 8'h02, S_NVS = 8'h04, S_PGS = 8'h08,
    S_PULSE = 8'h10, S_NVH = 8'h20, S_RCV = 8'h40, S_RDCAP = 8'h80
  } state_e;

  state_e         state;
  logic [31:0]    tmr;
  logic [31:0]    t_nvs, t_pgs, t_write_pulse, t_ers, t_me, t_nvh, t_nvh1, t_rcv;
  logic [3:0]     cmd;
  logic [AW-1:0]  addr;
  logic [DW-1:0]  wdata, rdata;
  logic [3:0]     status;
  logic           acc;
  logic           go;
  logic [ROWS-1:0] [31:0] hv_used;
  logic [2**AW-1:0] written;
  logic [5:0]     row;
  logic           bad_cmd;

  assign acc     = PSEL & PENABLE;
  assign go      = acc & PWRITE & (PADDR == flash_seq_pkg::REG_CMD) & ~status[flash_seq_pkg::ST_BUSY];
  assign row     = 6'((addr >> ROW_SH) & (ROWS - 1));
  assign bad_cmd = (PWDATA[2:0] == 3'h0) || (PWDATA[2:0] > flash_seq_pkg::CMD_MERASE);

  ////////////////////////////////////////////////////////////////////////////
  // APB register writes; timing registers are programmable.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      t_nvs  <= 32'(flash_seq_pkg::NVS_CYC);
      t_pgs  <= 32'(flash_seq_pkg::PGS_CYC);
      t_write_pulse <= 32'(flash_seq_pkg::WRITE_PULSE_CYC);
      t_ers  <= 32'(flash_seq_pkg::ERASE_CYC);
      t_me   <= 32'(flash_seq_pkg::ME_CYC);
      t_nvh  <= 32'(flash_seq_pkg::NVH_CYC);
      t_nvh1 <= 32'(flash_seq_pkg::NVH1_CYC);
      t_rcv  <= 32'(flash_seq_pkg::RCV_CYC);
      addr   <= '0;
      wdata  <= '0;
      cmd    <= 4'h0;
    end else if (acc && PWRITE) begin
      case (PADDR)
        flash_seq_pkg::REG_T_NVS:  t_nvs  <= (PWDATA == 0) ? 32'h1 : PWDATA;
        flash_seq_pkg::REG_T_PGS:  t_pgs  <= (PWDATA == 0) ? 32'h1 : PWDATA;
        flash_seq_pkg::REG_T_WRITE_PULSE: t_write_pulse <= (PWDATA == 0) ? 32'h1 : PWDATA;
        flash_seq_pkg::REG_T_ERS:  t_ers  <= (PWDATA == 0) ? 32'h1 : PWDATA;
        flash_seq_pkg::REG_T_ME:   t_me   <= (PWDATA == 0) ? 32'h1 : PWDATA;
        flash_seq_pkg::REG_T_NVH:  t_nvh  <= (PWDATA == 0) ? 32'h1 : PWDATA;
        flash_seq_pkg::REG_T_NVH1: t_nvh1 <= (PWDATA == 0) ? 32'h1 : PWDATA;
        flash_seq_pkg::REG_T_RCV:  t_rcv  <= (PWDATA == 0) ? 32'h1 : PWDATA;
        flash_seq_pkg::REG_ADDR:   addr   <= status[0] ? addr : PWDATA[AW-1:0];
        flash_seq_pkg::REG_WDATA:  wdata  <= status[0] ? wdata : PWDATA[DW-1:0];
        flash_seq_pkg::REG_CMD:    cmd    <= go ? PWDATA[3:0] : cmd;
        default: ;
      endcase
    end
  end

  // APB read mux and answer; zero wait states, unmapped reads zero with error.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA  <= 32'h0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & (PADDR > flash_seq_pkg::REG_T_RCV || PADDR[1:0] != 2'h0);
      case (PADDR)
        flash_seq_pkg::REG_CMD:    PRDATA <= {28'h0, cmd};
        flash_seq_pkg::REG_ADDR:   PRDATA <= 32'(addr);
        flash_seq_pkg::REG_WDATA:  PRDATA <= 32'(wdata);
        flash_seq_pkg::REG_RDATA:  PRDATA <= 32'(rdata);
        flash_seq_pkg::REG_STATUS: PRDATA <= {28'h0, status};
        flash_seq_pkg::REG_T_NVS:  PRDATA <= t_nvs;
        flash_seq_pkg::REG_T_PGS:  PRDATA <= t_pgs;
        flash_seq_pkg::REG_T_WRITE_PULSE: PRDATA <= t_write_pulse;
        flash_seq_pkg::REG_T_ERS:  PRDATA <= t_ers;
        flash_seq_pkg::REG_T_ME:   PRDATA <= t_me;
        flash_seq_pkg::REG_T_NVH:  PRDATA <= t_nvh;
        flash_seq_pkg::REG_T_NVH1: PRDATA <= t_nvh1;
        flash_seq_pkg::REG_T_RCV:  PRDATA <= t_rcv;
        default:                   PRDATA <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Manual-step sequencer with one interval timer.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= S_IDLE;
      tmr   <= 32'h0;
      rdata <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          if (go && !bad_cmd) begin
            tmr   <= (PWDATA[2:0] == flash_seq_pkg::CMD_READ) ? 32'h1 : t_nvs;
            state <= (PWDATA[2:0] == flash_seq_pkg::CMD_READ) ? S_RDEN : S_NVS;
          end
        end
        S_RDEN: begin
          state <= S_RDCAP;
        end
        S_RDCAP: begin
          if (tmr != 0) begin
            tmr <= tmr - 32'h1;
          end else begin
            rdata <= FA.dout;
            state <= S_IDLE;
          end
        end
        S_NVS: begin
          if (tmr > 32'h1) begin
            tmr <= tmr - 32'h1;
          end else begin
            tmr   <= (cmd[2:0] == flash_seq_pkg::CMD_WRITE_PULSE) ? t_pgs : 32'h1;
            state <= (cmd[2:0] == flash_seq_pkg::CMD_WRITE_PULSE) ? S_PGS : S_PULSE;
          end
        end
        S_PGS: begin
          if (tmr > 32'h1) begin
            tmr <= tmr - 32'h1;
          end else begin
            tmr   <= t_write_pulse;
            state <= S_PULSE;
          end
        end
        S_PULSE: begin
          if (cmd[2:0] != flash_seq_pkg::CMD_WRITE_PULSE && tmr == 32'h1 && state == S_PULSE && FA.hv_store == 1'b0) begin
            tmr <= (cmd[2:0] == flash_seq_pkg::CMD_MERASE) ? t_me : t_ers;
          end else if (tmr > 32'h1) begin
            tmr <= tmr - 32'h1;
          end else begin
            tmr   <= (cmd[2:0] == flash_seq_pkg::CMD_MERASE) ? t_nvh1 : t_nvh;
            state <= S_NVH;
          end
        end
        S_NVH: begin
          if (tmr > 32'h1) begin
            tmr <= tmr - 32'h1;
          end else begin
            tmr   <= t_rcv;
            state <= S_RCV;
          end
        end
        S_RCV: begin
          if (tmr > 32'h1) begin
            tmr <= tmr - 32'h1;
          end else begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Strobe outputs registered from the current state and the command.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      {FA.row_select, FA.column_gate, FA.read_amplifier_on, FA.dout_drive} <= 4'h0;
      {FA.write_pulse, FA.clear_pulse, FA.whole_array, FA.hv_store} <= 4'h0;
      FA.info_block_sel <= 1'b0;
      FA.addr           <= '0;
      FA.din            <= '0;
    end else begin
      FA.info_block_sel <= cmd[flash_seq_pkg::CMD_INFO_BIT];
      FA.addr           <= addr;
      FA.din            <= wdata;
      FA.row_select        <= (state != S_IDLE) && (state != S_RCV);
      FA.column_gate       <= (state == S_RDEN || state == S_RDCAP ||
                              cmd[2:0] == flash_seq_pkg::CMD_WRITE_PULSE) && state != S_IDLE && state != S_RCV;
      FA.read_amplifier_on <= (state == S_RDEN || state == S_RDCAP);
      FA.dout_drive        <= (state == S_RDEN || state == S_RDCAP);
      FA.write_pulse       <= (cmd[2:0] == flash_seq_pkg::CMD_WRITE_PULSE) && (state == S_NVS || state == S_PGS ||
                              state == S_PULSE);
      FA.clear_pulse       <= (cmd[2:0] == flash_seq_pkg::CMD_PERASE || cmd[2:0] == flash_seq_pkg::CMD_MERASE)
                              && (state == S_NVS || state == S_PULSE);
      FA.whole_array       <= (cmd[2:0] == flash_seq_pkg::CMD_MERASE) && state != S_IDLE && state != S_RCV;
      FA.hv_store          <= state == S_PGS || state == S_PULSE || state == S_NVH;
    end
  end

  // Status, HV budget per row and duplicate-program guard.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      status  <= 4'h0;
      hv_used <= '0;
      written <= '0;
    end else begin
      status[flash_seq_pkg::ST_BUSY] <= (state != S_IDLE) || (go && !bad_cmd);
      if (go) begin
        status[3:1] <= {bad_cmd, 2'b00};
      end
      if (go && PWDATA[2:0] == flash_seq_pkg::CMD_WRITE_PULSE && written[addr]) begin
        status[flash_seq_pkg::ST_DUP_ERR] <= 1'b1;
      end
      if (go && PWDATA[2:0] == flash_seq_pkg::CMD_WRITE_PULSE && hv_used[row] >= 32'(HV_LIMIT)) begin
        status[flash_seq_pkg::ST_HV_ERR] <= 1'b1;
      end
      if (state == S_PULSE && FA.write_pulse && FA.hv_store) begin
        hv_used[row]  <= hv_used[row] + 32'h1;
        written[addr] <= 1'b1;
      end
      if (state == S_NVH && cmd[2:0] == flash_seq_pkg::CMD_MERASE) begin
        hv_used <= '0;
        written <= '0;
      end else if (state == S_NVH && cmd[2:0] == flash_seq_pkg::CMD_PERASE) begin
        hv_used[row] <= 32'h0;
      end
    end
  end

endmodule : flash_ctrl
`default_nettype wire

// [logic/flash_seq_pkg.sv]
// What this block does
// - Standby: all strobes low, rows deselected.
// - Read strobes set; data bus floats otherwise.
// - Page erase strobe pattern; column mux off.
// - Mass erase adds whole_array to erase.
// - Word program strobe pattern with hv_store.
// - info_block_sel picks block; mass erase with it set erases both.
// - hv_store rises 5 us after pulse.
// - Program pulse 10 us after hv_store.
// - hv_store held 5 us, 100 us mass.
// - Row program-pulse time at or past 3 ms sets ST_HV_ERR; the program still runs.
// - Reprogram without intervening mass erase sets ST_DUP_ERR; the program still runs.
// - Automatic intervals at least one cycle.
// - Controller applies intervals when stepping manually.
// - Intervals are programmable timing registers.
`default_nettype none
package flash_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing figures and derived cycle counts at 40 MHz.
  localparam int CLK_MHZ        = 40;
  localparam int T_NVS_US       = 5;
  localparam int T_PGS_US       = 10;
  localparam int T_NVH_US       = 5;
  localparam int T_NVH1_US      = 100;
  localparam int T_RCV_US       = 1;
  localparam int T_WRITE_PULSE_US      = 20;
  localparam int T_ERASE_MS     = 20;
  localparam int T_ME_MS        = 100;
  localparam int T_HV_MS        = 3;
  localparam int NVS_CYC        = T_NVS_US * CLK_MHZ;
  localparam int PGS_CYC        = T_PGS_US * CLK_MHZ;
  localparam int NVH_CYC        = T_NVH_US * CLK_MHZ;
  localparam int NVH1_CYC       = T_NVH1_US * CLK_MHZ;
  localparam int RCV_CYC        = T_RCV_US * CLK_MHZ;
  localparam int WRITE_PULSE_CYC       = T_WRITE_PULSE_US * CLK_MHZ;
  localparam int ERASE_CYC      = T_ERASE_MS * 1000 * CLK_MHZ;
  localparam int ME_CYC         = T_ME_MS * 1000 * CLK_MHZ;
  localparam int HV_CYC         = T_HV_MS * 1000 * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // APB register offsets of the controller.
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_T_NVS  = 8'h14;
  localparam logic [7:0] REG_T_PGS  = 8'h18;
  localparam logic [7:0] REG_T_WRITE_PULSE = 8'h1C;
  localparam logic [7:0] REG_T_ERS  = 8'h20;
  localparam logic [7:0] REG_T_ME   = 8'h24;
  localparam logic [7:0] REG_T_NVH  = 8'h28;
  localparam logic [7:0] REG_T_NVH1 = 8'h2C;
  localparam logic [7:0] REG_T_RCV  = 8'h30;

  // Command codes written to the command register bits 2:0; bit 3 is info_block_sel.
  localparam logic [2:0] CMD_READ   = 3'h1;
  localparam logic [2:0] CMD_WRITE_PULSE   = 3'h2;
  localparam logic [2:0] CMD_PERASE = 3'h3;
  localparam logic [2:0] CMD_MERASE = 3'h4;
  localparam int         CMD_INFO_BIT = 3;

  // Status bit positions.
  localparam int ST_BUSY    = 0;
  localparam int ST_HV_ERR  = 1;
  localparam int ST_DUP_ERR = 2;
  localparam int ST_BAD_CMD = 3;

endpackage : flash_seq_pkg
`default_nettype wire

// [tb/flash_array_checker.sv]
`timescale 1ns/100ps
`default_nettype none
// Watches the strobes between controller and array; phase counts match the timing values the bench programs.
module flash_array_checker (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Array strobes.
  input wire logic row_select,
  input wire logic column_gate,
  input wire logic read_amplifier_on,
  input wire logic dout_drive,
  input wire logic write_pulse,
  input wire logic clear_pulse,
  input wire logic whole_array,
  input wire logic hv_store,
  // Array output enable.
  input wire logic dout_oe
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);

  ////////////////////////////////////////////////////////////////////////////
  // Strobe patterns of each mode.
  AST_STANDBY: assert property (!row_select |-> !(column_gate || read_amplifier_on || dout_drive || write_pulse
    || clear_pulse || hv_store)) else $error("strobe active with rows deselected");
  AST_READ_PAT: assert property (read_amplifier_on |-> row_select && column_gate && !write_pulse && !clear_pulse
    && !whole_array && !hv_store) else $error("bad read strobe pattern");
  AST_FLOAT: assert property (!dout_drive && !$past(dout_drive) |-> !dout_oe)
    else $error("array drives data with output off");
  AST_ERASE_PAT: assert property (clear_pulse |-> row_select && !column_gate && !read_amplifier_on
    && !dout_drive && !write_pulse) else $error("bad erase strobe pattern");
  AST_MASS_PAT: assert property (whole_array |-> row_select && !column_gate && !write_pulse)
    else $error("bad mass erase strobe pattern");
  AST_WRITE_PULSE_PAT: assert property (write_pulse |-> row_select && column_gate && !read_amplifier_on && !dout_drive
    && !clear_pulse && !whole_array) else $error("bad program strobe pattern");

  ////////////////////////////////////////////////////////////////////////////
  // Phase lengths: every timing value 4 cycles, mass erase hold 8.
  AST_NVS: assert property ($rose(write_pulse || clear_pulse) |-> !hv_store [*4])
    else $error("store raised too early");
  AST_PGS: assert property ($rose(hv_store) && write_pulse |-> write_pulse [*8])
    else $error("program pulse too short");
  AST_ERS_LEN: assert property ($rose(hv_store) && clear_pulse |-> clear_pulse [*4])
    else $error("erase pulse too short");
  AST_NVH: assert property ($fell(write_pulse) || ($fell(clear_pulse) && !whole_array) |-> hv_store [*4])
    else $error("store hold too short");
  AST_NVH1: assert property ($fell(clear_pulse) && $past(whole_array) |-> hv_store [*8])
    else $error("mass erase store hold too short");
  AST_RCV: assert property ($fell(hv_store) |-> !(read_amplifier_on || write_pulse || clear_pulse) [*4])
    else $error("operation started during recovery");

  // Main scenarios seen.
  CV_READ: cover property ($rose(read_amplifier_on));
  CV_WRITE_PULSE: cover property ($rose(write_pulse));
  CV_PERASE: cover property ($rose(clear_pulse) && !whole_array);
  CV_MERASE: cover property ($rose(clear_pulse) && whole_array);
endmodule : flash_array_checker
`default_nettype wire

// [tb/flash_array_mode_sequencer_tb.sv]
`timescale 1ns/100ps
`default_nettype none
// Bench joining controller and array, driven over APB.
module flash_array_mode_sequencer_tb;
  localparam logic [15:0] ERASED = 16'hFFFF; // Erased word reads all ones.
  logic        CLK_SYS = 1'b0;
  logic        ARST_N = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [4:0]  MODE;
  logic [4:0]  mode_seen = 5'h00;
  logic [31:0] rd;
  logic        er;
  logic [15:0] d1;
  logic [12:0] a;
  integer      seed = 32'h42d823c3;
  int          err_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  flash_array_if #(.AW(13), .DW(16)) fa_if ();
  flash_ctrl #(.HV_LIMIT(40)) flash_ctrl_inst (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FA(fa_if));
  flash_array flash_array_inst (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .FA(fa_if), .MODE(MODE));
  flash_array_checker flash_array_checker_inst (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
    .row_select(fa_if.row_select), .column_gate(fa_if.column_gate), .read_amplifier_on(fa_if.read_amplifier_on),
    .dout_drive(fa_if.dout_drive), .write_pulse(fa_if.write_pulse), .clear_pulse(fa_if.clear_pulse),
    .whole_array(fa_if.whole_array), .hv_store(fa_if.hv_store), .dout_oe(fa_if.dout_oe));

  // Clock at 40 MHz.
  always #12.5 CLK_SYS = ~CLK_SYS;

  // Cuts a hung run short and collects every mode the array has reported.
  always @(posedge CLK_SYS) begin
    cycles++;
    if (ARST_N) mode_seen <= mode_seen | MODE;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compares a value and counts the result.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Programming can only clear bits of a stored word.
  function automatic logic [15:0] write_pulse_word(input logic [15:0] old, input logic [15:0] wd);
    return old & wd;
  endfunction : write_pulse_word

  // One APB transfer; read data and error are taken at the edge that sees PREADY.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    check("pready_waits", 32'(n), 32'h1);
  endtask : apb

  // Polls status until the sequencer is idle; leaves the status word in rd.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, flash_seq_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[flash_seq_pkg::ST_BUSY] !== 1'b0 && n < 500);
    check("busy", {31'h0, rd[flash_seq_pkg::ST_BUSY]}, 32'h0);
  endtask : wait_idle

  // Address, data, then command, then wait.
  task automatic op(input logic [2:0] code, input logic info, input logic [12:0] ad, input logic [15:0] wd);
    apb(1'b1, flash_seq_pkg::REG_ADDR, {19'h0, ad});
    apb(1'b1, flash_seq_pkg::REG_WDATA, {16'h0, wd});
    apb(1'b1, flash_seq_pkg::REG_CMD, {28'h0, info, code});
    wait_idle();
  endtask : op

  // Reads one word of the array and compares it.
  task automatic rd_word(input logic info, input logic [12:0] ad, input logic [15:0] exp, input string nm);
    op(flash_seq_pkg::CMD_READ, info, ad, 16'h0);
    apb(1'b0, flash_seq_pkg::REG_RDATA, 32'h0);
    check(nm, {16'h0, rd[15:0]}, {16'h0, exp});
  endtask : rd_word

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (6) @(posedge CLK_SYS);
    ARST_N <= 1'b1;
    apb(1'b1, flash_seq_pkg::REG_T_RCV, 32'h0);
    apb(1'b0, flash_seq_pkg::REG_T_RCV, 32'h0);
    check("zero_stores_one", rd, 32'h1);
    check("slverr_mapped", {31'h0, er}, 32'h0);
    for (int i = 0; i < 8; i++) apb(1'b1, 8'h14 + 8'(4 * i), (i == 6) ? 32'h8 : 32'h4);
    apb(1'b0, 8'h34, 32'h0);
    check("slverr_unmapped", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h05, 32'h0);
    check("slverr_misaligned", {31'h0, er}, 32'h1);
    apb(1'b1, flash_seq_pkg::REG_CMD, {29'h0, 3'h5});
    apb(1'b0, flash_seq_pkg::REG_STATUS, 32'h0);
    check("bad_cmd", {31'h0, rd[flash_seq_pkg::ST_BAD_CMD]}, 32'h1);
    check("bad_cmd_idle", {31'h0, rd[flash_seq_pkg::ST_BUSY]}, 32'h0);
    check("mode_standby", {27'h0, MODE}, 32'h1);
    $display("test registers done");
    a = 13'($random(seed)) & 13'h001F;
    d1 = 16'($random(seed));
    op(flash_seq_pkg::CMD_MERASE, 1'b1, 13'h0, 16'h0);
    op(flash_seq_pkg::CMD_WRITE_PULSE, 1'b0, a, d1);
    op(flash_seq_pkg::CMD_WRITE_PULSE, 1'b1, a, ~d1);
    rd_word(1'b0, a, d1, "main_word");
    rd_word(1'b1, a, ~d1, "info_word");
    op(flash_seq_pkg::CMD_PERASE, 1'b1, a, 16'h0);
    rd_word(1'b1, a, ERASED, "info_erased");
    rd_word(1'b0, a, d1, "main_kept");
    op(flash_seq_pkg::CMD_MERASE, 1'b0, 13'h0, 16'h0);
    rd_word(1'b0, a, ERASED, "main_erased");
    $display("test block_select done");
    apb(1'b1, flash_seq_pkg::REG_ADDR, {19'h0, a});
    apb(1'b1, flash_seq_pkg::REG_WDATA, {16'h0, d1});
    apb(1'b1, flash_seq_pkg::REG_CMD, {29'h0, flash_seq_pkg::CMD_WRITE_PULSE});
    apb(1'b1, flash_seq_pkg::REG_CMD, {29'h0, flash_seq_pkg::CMD_MERASE});
    wait_idle();
    check("dup_clear", {31'h0, rd[flash_seq_pkg::ST_DUP_ERR]}, 32'h0);
    rd_word(1'b0, a, d1, "busy_refused");
    op(flash_seq_pkg::CMD_WRITE_PULSE, 1'b0, a, ~d1);
    check("dup_set", {31'h0, rd[flash_seq_pkg::ST_DUP_ERR]}, 32'h1);
    $display("test reprogram done");
    for (int i = 0; i < 12; i++) begin
      op(flash_seq_pkg::CMD_WRITE_PULSE, 1'b0, 13'h0080 + 13'(i), 16'($random(seed)));
      if (i == 0) check("hv_ok", {31'h0, rd[flash_seq_pkg::ST_HV_ERR]}, 32'h0);
    end
    check("hv_over", {31'h0, rd[flash_seq_pkg::ST_HV_ERR]}, 32'h1);
    $display("test hv_budget done");
    op(flash_seq_pkg::CMD_PERASE, 1'b0, 13'h0080, 16'h0);
    rd_word(1'b0, 13'h0080, ERASED, "page_erased");
    rd_word(1'b0, a, write_pulse_word(d1, ~d1), "page_other_kept");
    check("modes_seen", {27'h0, mode_seen}, 32'h1F);
    $display("test page_erase done");
    final_report();
  end
endmodule : flash_array_mode_sequencer_tb
`default_nettype wire
